// [src/acs_regs.svh]
// register offsets, field positions, reset values and timing counts
// Functional notes
// - pointer stays set; each 16-bit register reads as two bytes, repeatedly.
// - master NACKs last byte; device then releases data line for stop.
// - read is start, address with read bit, ACKs per byte, then stop.
// - core starts in partial power-down and stays there when idle.
// - addressing the device by its slave address leaves power-down.
// - on-demand is default; control write at 0x00 stores channel set.
// - first on-demand conversion starts only on read of result register.
// - on-demand conversion completes while channel id bits shift out.
// - next on-demand conversion starts only when next result read begins.
// - selected channels convert in ascending order from the lowest.
// - after last selected channel, wrap to the first selected again.
// - stop in on-demand mode halts, powers down, keeps control value.
// - after an on-demand stop, sequence restarts at the first selected channel.
// - result is channel id plus 4 MSBs, then 8 LSBs.
// - voltage result register sits at offset 0x01, read via pointer.
// - control write aborts running sequence; next is new lowest channel.
// - channel select in D15..D8, one per channel; D0 enables autocycle.
// - autocycle is off after reset until software sets D0.
// - autocycle converts about every 50 us, looping low to high.
// - autocycle results compared to limits; alert pin polarity from D3.
// - bus access allowed in autocycle; result holds latest conversion.
// - stop does not power down in autocycle; monitoring continues.
// - slave address is 010 followed by four strap-set bits.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_RESULT 8'h01
`define ACS_CTRL_RST 16'h0000
`define ACS_CTRL_AUTO_BIT 0
`define ACS_CTRL_POL_BIT 3
`define ACS_CTRL_SEL_MSB 15
`define ACS_ADDR_FIXED 3'h2
`define ACS_CLK_NS 50
`define ACS_CONV_NS 4450
`define ACS_AUTO_NS 50000
`define ACS_CONV_CYC ((`ACS_CONV_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_AUTO_CYC (`ACS_AUTO_NS / `ACS_CLK_NS)
`endif

// [src/acs_pkg.sv]
// types of the conversion sequencer
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b000,
    ACS_RX = 3'b001,
    ACS_ACK = 3'b010,
    ACS_TX = 3'b011,
    ACS_MACK = 3'b100
  } acs_bus_st_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } acs_line_t;

  typedef struct packed {
    acs_bus_st_t st;
    acs_line_t prev;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic addr_phase;
    logic rd;
    logic [1:0] wbyte;
    logic [7:0] wr_msb;
    logic [7:0] ptr;
    logic hi_half;
    logic sda_oe;
    logic [15:0] ctrl;
    logic [15:0] result;
    logic busy;
    logic [11:0] conv_cnt;
    logic [3:0] conv_chan;
    logic [3:0] last_chan;
    logic restart;
    logic [11:0] auto_cnt;
    logic pd;
    logic [15:0] alert_status;
    logic alert;
  } acs_state_t;
endpackage

// [src/acs_sequencer.sv]
// two-wire slave, on-demand and autocycle conversion sequencer
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_sequencer #(
  parameter int CONV_CYC = `ACS_CONV_CYC,
  parameter int AUTO_CYC = `ACS_AUTO_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  input wire logic [11:0] conv_data,
  input wire logic [11:0] lim_high,
  input wire logic [11:0] lim_low,
  output logic [3:0] conv_chan,
  output logic conv_active,
  output logic power_down,
  output logic [15:0] alert_status,
  output logic alert
);

  acs_pkg::acs_state_t s_r;
  acs_pkg::acs_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // lowest selected channel at or above start, else lowest overall
  function automatic logic [3:0] pick_chan(input logic [15:0] ctrl,
                                           input logic [3:0] start);
    logic [3:0] above;
    logic [3:0] lowest;
    logic got_above;
    logic got_low;
    above = 4'h0;
    lowest = 4'h0;
    got_above = 1'b0;
    got_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (ctrl[`ACS_CTRL_SEL_MSB - i]) begin
        if (!got_low) begin
          lowest = 4'(i);
          got_low = 1'b1;
        end
        if (!got_above && 4'(i) >= start) begin
          above = 4'(i);
          got_above = 1'b1;
        end
      end
    end
    pick_chan = got_above ? above : lowest;
  endfunction

  function automatic logic any_sel(input logic [15:0] ctrl);
    any_sel = |ctrl[`ACS_CTRL_SEL_MSB -: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus edges and read data

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic my_addr;
  logic [15:0] rd_word;
  logic auto_on;

  assign scl_rise = scl_i && !s_r.prev.scl;
  assign scl_fall = !scl_i && s_r.prev.scl;
  assign start_cond = scl_i && s_r.prev.scl && s_r.prev.sda && !sda_i;
  assign stop_cond = scl_i && s_r.prev.scl && !s_r.prev.sda && sda_i;
  assign my_addr = s_r.sh[7:1] ==
                   {`ACS_ADDR_FIXED, addr_strap_high, addr_strap_low};
  assign auto_on = s_r.ctrl[`ACS_CTRL_AUTO_BIT];

  always_comb begin
    if (s_r.ptr == `ACS_OFS_CTRL) begin
      rd_word = s_r.ctrl;
    end else if (s_r.ptr == `ACS_OFS_RESULT) begin
      rd_word = s_r.result;
    end else begin
      rd_word = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic start_req;
    logic [3:0] tx_idx;
    logic [3:0] ch;
    start_req = 1'b0;
    tx_idx = 4'h0;
    ch = 4'h0;
    s_nxt = s_r;
    s_nxt.prev.scl = scl_i;
    s_nxt.prev.sda = sda_i;

    // serial slave
    if (start_cond) begin
      s_nxt.st = acs_pkg::ACS_RX;
      s_nxt.cnt = 4'h0;
      s_nxt.addr_phase = 1'b1;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      s_nxt.st = acs_pkg::ACS_IDLE;
      s_nxt.sda_oe = 1'b0;
      if (!auto_on) begin
        s_nxt.busy = 1'b0;
        s_nxt.pd = 1'b1;
        s_nxt.restart = 1'b1;
      end
    end else begin
      case (s_r.st)
        acs_pkg::ACS_RX: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_i};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == 4'h8) begin
            if (s_r.addr_phase) begin
              if (my_addr) begin
                s_nxt.st = acs_pkg::ACS_ACK;
                s_nxt.sda_oe = 1'b1;
                s_nxt.rd = s_r.sh[0];
                s_nxt.addr_phase = 1'b0;
                s_nxt.wbyte = 2'h0;
                s_nxt.hi_half = 1'b1;
                s_nxt.pd = 1'b0;
              end else begin
                s_nxt.st = acs_pkg::ACS_IDLE;
              end
            end else begin
              s_nxt.st = acs_pkg::ACS_ACK;
              s_nxt.sda_oe = 1'b1;
              // offset, then MSB, then LSB, repeating
              case (s_r.wbyte)
                2'h0: begin
                  s_nxt.ptr = s_r.sh;
                  s_nxt.wbyte = 2'h1;
                end
                2'h1: begin
                  s_nxt.wr_msb = s_r.sh;
                  s_nxt.wbyte = 2'h2;
                end
                default: begin
                  s_nxt.wbyte = 2'h0;
                  if (s_r.ptr == `ACS_OFS_CTRL) begin
                    s_nxt.ctrl = {s_r.wr_msb, s_r.sh};
                    s_nxt.restart = 1'b1;
                    s_nxt.auto_cnt = 12'h000;
                    if (!s_r.sh[`ACS_CTRL_AUTO_BIT]) begin
                      s_nxt.busy = 1'b0;
                    end
                  end
                end
              endcase
            end
          end
        end
        acs_pkg::ACS_ACK: begin
          if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.rd) begin
              s_nxt.st = acs_pkg::ACS_TX;
              start_req = 1'b1;
            end else begin
              s_nxt.st = acs_pkg::ACS_RX;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        acs_pkg::ACS_TX: begin
          if (scl_rise) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_r.cnt == 4'h8) begin
              s_nxt.st = acs_pkg::ACS_MACK;
              s_nxt.sda_oe = 1'b0;
            end else begin
              tx_idx = s_r.hi_half ? 4'hf - s_r.cnt : 4'h7 - s_r.cnt;
              s_nxt.sda_oe = !rd_word[tx_idx];
            end
          end
        end
        acs_pkg::ACS_MACK: begin
          if (scl_rise) begin
            if (sda_i) begin
              s_nxt.st = acs_pkg::ACS_IDLE;
            end else begin
              s_nxt.hi_half = !s_r.hi_half;
            end
          end else if (scl_fall) begin
            s_nxt.st = acs_pkg::ACS_TX;
            s_nxt.cnt = 4'h0;
            start_req = 1'b1;
          end
        end
        default: begin
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // first bit of a byte and on-demand conversion start
    if (start_req) begin
      if (s_nxt.hi_half && !auto_on && s_r.ptr == `ACS_OFS_RESULT &&
          any_sel(s_r.ctrl)) begin
        ch = s_r.restart ? pick_chan(s_r.ctrl, 4'h0)
                         : pick_chan(s_r.ctrl, s_r.last_chan + 4'h1);
        s_nxt.busy = 1'b1;
        s_nxt.conv_cnt = 12'h000;
        s_nxt.conv_chan = ch;
        s_nxt.last_chan = ch;
        s_nxt.restart = 1'b0;
        s_nxt.result = {ch, 12'h000};
      end
      tx_idx = s_nxt.hi_half ? 4'hf : 4'h7;
      if (s_nxt.hi_half && !auto_on && s_r.ptr == `ACS_OFS_RESULT &&
          any_sel(s_r.ctrl)) begin
        s_nxt.sda_oe = !ch[3];
      end else begin
        s_nxt.sda_oe = !rd_word[tx_idx];
      end
    end

    // autocycle timer
    if (auto_on && any_sel(s_r.ctrl)) begin
      s_nxt.pd = 1'b0;
      if (s_r.auto_cnt == 12'(AUTO_CYC - 1)) begin
        s_nxt.auto_cnt = 12'h000;
        if (!s_r.busy) begin
          ch = s_r.restart ? pick_chan(s_r.ctrl, 4'h0)
                           : pick_chan(s_r.ctrl, s_r.last_chan + 4'h1);
          s_nxt.busy = 1'b1;
          s_nxt.conv_cnt = 12'h000;
          s_nxt.conv_chan = ch;
          s_nxt.last_chan = ch;
          s_nxt.restart = 1'b0;
        end
      end else begin
        s_nxt.auto_cnt = s_r.auto_cnt + 12'h001;
      end
    end

    // conversion core
    if (s_r.busy && s_nxt.busy) begin
      if (s_r.conv_cnt == 12'(CONV_CYC - 1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.result = {s_r.conv_chan, conv_data};
        if (auto_on) begin
          if (conv_data > lim_high) begin
            s_nxt.alert_status[{s_r.conv_chan[2:0], 1'b1}] = 1'b1;
          end
          if (conv_data < lim_low) begin
            s_nxt.alert_status[{s_r.conv_chan[2:0], 1'b0}] = 1'b1;
          end
        end
      end else begin
        s_nxt.conv_cnt = s_r.conv_cnt + 12'h001;
      end
    end

    // idle core drops back to power-down
    if (!s_nxt.busy && !auto_on && s_nxt.st == acs_pkg::ACS_IDLE) begin
      s_nxt.pd = 1'b1;
    end

    s_nxt.alert = (|s_nxt.alert_status) ? s_nxt.ctrl[`ACS_CTRL_POL_BIT]
                                        : !s_nxt.ctrl[`ACS_CTRL_POL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= acs_pkg::ACS_IDLE;
      s_r.prev <= 2'b11;
      s_r.ctrl <= `ACS_CTRL_RST;
      s_r.restart <= 1'b1;
      s_r.hi_half <= 1'b1;
      s_r.pd <= 1'b1;
      s_r.alert <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = s_r.sda_oe;
  assign conv_chan = s_r.conv_chan;
  assign conv_active = s_r.busy;
  assign power_down = s_r.pd;
  assign alert_status = s_r.alert_status;
  assign alert = s_r.alert;

endmodule // acs_sequencer

// [test/acs_monitor.sv]
// port assertions of the conversion sequencer
`timescale 1ns/1ps
module acs_monitor #(
  parameter int CONV_CYC = 89
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic [3:0] conv_chan,
  input wire logic conv_active,
  input wire logic power_down,
  input wire logic [15:0] alert_status
);
  int run_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 0;
    end else begin
      run_r <= conv_active ? run_r + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  boot_pd_a: assert property (
    $fell(sys_rst) |-> power_down && !conv_active)
    else $error("core awake after reset");
  conv_len_a: assert property (
    run_r <= CONV_CYC + 1)
    else $error("conversion too long");
  awake_conv_a: assert property (
    conv_active |-> !power_down)
    else $error("converting while powered down");
  chan_hold_a: assert property (
    conv_active && $past(conv_active) |-> $stable(conv_chan))
    else $error("channel moved mid conversion");
  sda_steady_a: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  stop_quiet_a: assert property (
    scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe [*2])
    else $error("data driven after stop");
  status_keep_a: assert property (
    ($past(alert_status) & ~alert_status) == 16'h0)
    else $error("alert status bit cleared");
  status_conv_a: assert property (
    $changed(alert_status) |-> $past(conv_active) || $past(conv_active, 2))
    else $error("status changed outside conversion");
  awake_bus_a: assert property (
    sda_oe |-> ##[0:2] !power_down)
    else $error("addressed but still powered down");
endmodule // acs_monitor

bind acs_sequencer acs_monitor #(.CONV_CYC(CONV_CYC)) u_mon (
  .clk, .sys_rst, .scl_i, .sda_i, .sda_oe, .conv_chan, .conv_active,
  .power_down, .alert_status
);

// [test/acs_master_model.sv]
// two-wire bus master model with open-drain data pull
`timescale 1ns/1ps
module acs_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  localparam int H = 5;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    gap(1);
    pull = !b;
    gap(H);
    scl = 1'b1;
    gap(H);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start;
    pull = 1'b0;
    gap(H);
    scl = 1'b1;
    gap(H);
    pull = 1'b1;
    gap(H);
    scl = 1'b0;
  endtask
  task automatic stop;
    gap(1);
    pull = 1'b1;
    gap(H);
    scl = 1'b1;
    gap(H);
    pull = 1'b0;
    gap(H);
  endtask
  task automatic wb(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic rb(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule // acs_master_model

// [test/tb.sv]
// testbench of the conversion sequencer
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, scl, sda, pull, sda_oe, conv_active, power_down, alert;
  logic [3:0] conv_chan;
  logic [15:0] alert_status;
  logic [11:0] lim_low, lim_high;
  int n_fail, num_checks;
  localparam logic [6:0] DEV = 7'h29;
  assign sda = !(pull || sda_oe);
  acs_master_model mst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  acs_sequencer #(.CONV_CYC(4), .AUTO_CYC(40)) dut (
    .clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .addr_strap_low(2'h1), .addr_strap_high(2'h2),
    .conv_data({conv_chan, 8'ha5}), .lim_high(lim_high), .lim_low(lim_low),
    .conv_chan(conv_chan), .conv_active(conv_active),
    .power_down(power_down), .alert_status(alert_status), .alert(alert)
  );
  task automatic chk(input string nm, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [15:0] w(input logic [3:0] c);
    return {c, c, 8'ha5};
  endfunction
  task automatic wr(input logic [7:0] q[$]);
    logic a;
    mst.start();
    mst.wb({DEV, 1'b0}, a);
    chk("wr ack", a, 16'h0);
    foreach (q[i]) begin
      mst.wb(q[i], a);
      chk("byte ack", a, 16'h0);
    end
  endtask
  task automatic rd(input logic [15:0] e[$], input logic sp);
    logic a;
    logic [7:0] hi, lo;
    mst.start();
    mst.wb({DEV, 1'b1}, a);
    chk("rd ack", a, 16'h0);
    chk("awake", power_down, 16'h0);
    foreach (e[i]) begin
      mst.rb(1'b0, hi);
      mst.rb(i == e.size() - 1, lo);
      chk("word", {hi, lo}, e[i]);
    end
    if (sp) begin
      mst.stop();
    end
  endtask
  task automatic sc_reset;
    logic a;
    chk("pd", power_down, 16'h1);
    chk("alert", alert, 16'h1);
    chk("status", alert_status, 16'h0);
    mst.start();
    mst.wb({7'h2a, 1'b1}, a);
    chk("foreign ack", a, 16'h1);
    mst.stop();
  endtask
  task automatic sc_demand;
    wr('{8'h00, 8'h70, 8'h00, 8'h01});
    mst.stop();
    chk("no conv", conv_active, 16'h0);
    rd('{w(1), w(2), w(3), w(1)}, 1'b1);
    chk("pd stop", power_down, 16'h1);
    rd('{w(1), w(2)}, 1'b1);
  endtask
  task automatic sc_abort;
    rd('{w(1), w(2)}, 1'b0);
    wr('{8'h00, 8'h50, 8'h00, 8'h01});
    rd('{w(1), w(3), w(1)}, 1'b1);
  endtask
  task automatic sc_auto;
    lim_low = 12'h0b0;
    wr('{8'h00, 8'h80, 8'h01, 8'h01});
    mst.stop();
    repeat (200) @(posedge clk);
    #1;
    chk("auto pd", power_down, 16'h0);
    chk("status", alert_status, 16'h0001);
    chk("alert lo", alert, 16'h0);
    rd('{w(0), w(0)}, 1'b1);
    wr('{8'h00, 8'h80, 8'h09});
    mst.stop();
    repeat (100) @(posedge clk);
    #1;
    chk("alert hi", alert, 16'h1);
    lim_high = 12'h0a0;
    repeat (100) @(posedge clk);
    #1;
    chk("status hi", alert_status, 16'h0003);
    rd('{16'h8009}, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    lim_low = 12'h000;
    lim_high = 12'hfff;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    sc_reset();
    sc_demand();
    sc_abort();
    sc_auto();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule // tb
